// *** rtl/pcm_pkg.sv ***
package pcm_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFF_CORE_SET = 8'h00;
   localparam logic [7:0] OFF_CORE_CLR = 8'h04;
   localparam logic [7:0] OFF_CORE_STATE = 8'h08;
   localparam logic [7:0] OFF_PER_SET = 8'h10;
   localparam logic [7:0] OFF_PER_CLR = 8'h14;
   localparam logic [7:0] OFF_PER_STATE = 8'h18;
   localparam logic [7:0] OFF_CFG = 8'h20;
   localparam logic [7:0] OFF_PWR_CMD = 8'h28;
   localparam logic [7:0] OFF_PWR_CFG = 8'h2C;
   localparam logic [7:0] OFF_OSC_STATE = 8'h30;
   localparam logic [7:0] OFF_IRQ_SET = 8'h34;
   localparam logic [7:0] OFF_IRQ_CLR = 8'h38;
   localparam logic [7:0] OFF_IRQ_STATE = 8'h3C;
   localparam logic [31:0] PER_MASK = 32'h0007EFFC;
   localparam logic CORE_RESET = 1'b1;
   localparam logic [31:0] PER_RESET = 32'h00000000;
   localparam logic [31:0] CFG_RESET = 32'h00000000;
   localparam logic [7:0] PWR_CFG_RESET = 8'h01;
   localparam int CFG_BYP = 0;
   localparam int CFG_OSC_EN = 1;
   localparam int CFG_CKO_DIS = 2;
   localparam int CFG_PRESCALE_SEL_LSB = 4;
   localparam int CFG_MUL_LSB = 8;
   localparam int CFG_CSS_LSB = 14;
   localparam int CFG_OSCNT_LSB = 16;
   localparam int CFG_PLLCNT_LSB = 24;
   localparam int CMD_SHD = 0;
   localparam int CMD_WAKE = 1;
   localparam int PSEL_SHD_LSB = 0;
   localparam int PSEL_WAKE_LSB = 2;
   localparam logic [2:0] PRESCALE_SEL_RSVD = 3'h7;
   localparam logic [1:0] CSS_SLOW = 2'h0;
   localparam logic [1:0] CSS_OSC = 2'h1;
   localparam logic [1:0] CSS_PLL = 2'h2;
   localparam logic [1:0] CSS_RSVD = 2'h3;
   localparam logic [1:0] PIN_TRIS = 2'h0;
   localparam logic [1:0] PIN_LOW = 2'h1;
   localparam logic [1:0] PIN_HIGH = 2'h2;
   localparam int SLOW_HZ = 32768;
   localparam int SYS_HZ = 200000000;
   localparam int OSC_TICK_DIV = 8;
   localparam int SLOW_CYC = SYS_HZ / SLOW_HZ;
   localparam logic [15:0] SLOW_CYC_M1 = 16'(SLOW_CYC - 1);
   localparam logic [2:0] OSC_DIV_M1 = 3'(OSC_TICK_DIV - 1);
   typedef enum logic [1:0] {PCM_PIN_TRIS, PCM_PIN_LOW, PCM_PIN_HIGH} pcm_pin_t;
endpackage

// *** rtl/pcm_bus_if.sv ***
`timescale 1ns/1ps
interface pcm_bus_if;
   logic wr;
   logic rd;
   logic [7:0] addr;
   logic [31:0] wdata;
   modport master (output wr, output rd, output addr, output wdata);
   modport slave (input wr, input rd, input addr, input wdata);
endinterface

// *** rtl/pcm_slow_timer.sv ***
`timescale 1ns/1ps
module pcm_slow_timer
   import pcm_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   output logic slow_tick,
   output logic osc_tick
);
   logic [15:0] cnt;
   logic [2:0] div;
   wire cnt_wrap = (cnt == SLOW_CYC_M1);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt <= 16'h0000;
         div <= 3'h0;
         slow_tick <= 1'b0;
         osc_tick <= 1'b0;
      end else begin
         cnt <= cnt_wrap ? 16'h0000 : cnt + 16'h0001;
         slow_tick <= cnt_wrap;
         osc_tick <= cnt_wrap && (div == OSC_DIV_M1);
         if (cnt_wrap) begin
            div <= div + 3'h1;
         end
      end
   end
endmodule // pcm_slow_timer

// *** rtl/pcm_regs.sv ***
`timescale 1ns/1ps
module pcm_regs
   import pcm_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [pcm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pcm_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [pcm_pkg::DATA_W-1:0] reg_rdata,
   output logic core_clk_en,
   output logic [pcm_pkg::DATA_W-1:0] periph_clk_en,
   output logic osc_enable,
   output logic osc_bypass,
   output logic clkout_oe,
   output logic [2:0] prescale_sel,
   output logic [5:0] pll_multiplier,
   output logic pll_enable,
   output logic [1:0] clock_source_sel,
   output logic osc_stable_flag,
   output logic pll_lock_flag,
   output logic power_off_pin_out,
   output logic power_off_pin_oe
);
   import pcm_pkg::*;

   pcm_bus_if bus ();
   assign bus.wr = reg_wr;
   assign bus.rd = reg_rd;
   assign bus.addr = reg_addr;
   assign bus.wdata = reg_wdata;

   logic slow_tick;
   logic osc_tick;
   pcm_slow_timer u_timer (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .slow_tick(slow_tick),
      .osc_tick(osc_tick)
   );

   logic [31:0] cfg;
   logic [7:0] pwr_cfg;
   logic [1:0] irq_mask;
   logic [7:0] osc_cnt;
   logic [7:0] pll_cnt;
   logic osc_stable;
   logic pll_locked;
   logic [1:0] pin_state;

   function automatic logic wr_at(input logic [7:0] off);
      wr_at = bus.wr && (bus.addr == off);
   endfunction

   function automatic logic [1:0] pin_code(input logic [1:0] sel, input logic [1:0] keep);
      pin_code = (sel == CSS_RSVD) ? keep : sel;
   endfunction

   wire w_core_set = wr_at(OFF_CORE_SET);
   wire w_core_clr = wr_at(OFF_CORE_CLR);
   wire w_per_set = wr_at(OFF_PER_SET);
   wire w_per_clr = wr_at(OFF_PER_CLR);
   wire w_cfg = wr_at(OFF_CFG);
   wire w_cmd = wr_at(OFF_PWR_CMD);
   wire w_pcfg = wr_at(OFF_PWR_CFG);
   wire w_irq_set = wr_at(OFF_IRQ_SET);
   wire w_irq_clr = wr_at(OFF_IRQ_CLR);

   // Proposed configuration fields
   wire [2:0] new_prescale_sel = bus.wdata[CFG_PRESCALE_SEL_LSB +: 3];
   wire [1:0] new_css = bus.wdata[CFG_CSS_LSB +: 2];
   wire [5:0] new_mul = bus.wdata[CFG_MUL_LSB +: 6];
   wire new_osc_en = bus.wdata[CFG_OSC_EN];
   wire [7:0] new_oscnt = bus.wdata[CFG_OSCNT_LSB +: 8];
   wire [5:0] new_pllcnt = bus.wdata[CFG_PLLCNT_LSB +: 6];
   wire [1:0] cur_css = cfg[CFG_CSS_LSB +: 2];
   wire [5:0] cur_mul = cfg[CFG_MUL_LSB +: 6];
   wire cur_osc_en = cfg[CFG_OSC_EN];

   // Leaving slow clock needs a stable oscillator; PLL also needs lock
   wire bad_rsvd = (new_prescale_sel == PRESCALE_SEL_RSVD) || (new_css == CSS_RSVD);
   wire bad_osc_sel = (new_css != CSS_SLOW) && (!new_osc_en || !osc_stable);
   wire bad_pll_sel = (new_css == CSS_PLL) && ((new_mul == 6'h00) || !pll_locked
                      || (new_mul != cur_mul));
   wire bad_pll_off = (new_mul == 6'h00) && (cur_mul != 6'h00) && (cur_css == CSS_PLL);
   wire bad_osc_off = !new_osc_en && cur_osc_en && (cur_css != CSS_SLOW);
   wire cfg_ok = !(bad_rsvd || bad_osc_sel || bad_pll_sel || bad_pll_off || bad_osc_off);
   wire cfg_take = w_cfg && cfg_ok;

   wire osc_start = cfg_take && new_osc_en && !cur_osc_en && (new_oscnt != 8'h00);
   wire pll_start = cfg_take && (new_mul != cur_mul) && (new_mul != 6'h00)
                    && (new_pllcnt != 6'h00);

   wire [1:0] shd_sel = pwr_cfg[PSEL_SHD_LSB +: 2];
   wire [1:0] wake_sel = pwr_cfg[PSEL_WAKE_LSB +: 2];
   // Wake has priority when both commands land in one write
   wire [1:0] next_pin_state = !w_cmd ? pin_state :
                               bus.wdata[CMD_WAKE] ? pin_code(wake_sel, pin_state) :
                               bus.wdata[CMD_SHD] ? pin_code(shd_sel, pin_state) :
                               pin_state;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         core_clk_en <= CORE_RESET;
      end else if (w_core_set && bus.wdata[0]) begin
         core_clk_en <= 1'b1;
      end else if (w_core_clr && bus.wdata[0]) begin
         core_clk_en <= 1'b0;
      end
   end

   // A set and clear of one bit cannot meet: strobes never overlap
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         periph_clk_en <= PER_RESET;
      end else if (w_per_set) begin
         periph_clk_en <= periph_clk_en | (bus.wdata & PER_MASK);
      end else if (w_per_clr) begin
         periph_clk_en <= periph_clk_en & ~(bus.wdata & PER_MASK);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg <= CFG_RESET;
      end else if (cfg_take) begin
         cfg <= bus.wdata & 32'h3FFFFF77;
      end
   end

   // Backup domain settings share the main reset here
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pwr_cfg <= PWR_CFG_RESET;
      end else if (w_pcfg) begin
         pwr_cfg <= bus.wdata[7:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irq_mask <= 2'h0;
      end else if (w_irq_set) begin
         irq_mask <= irq_mask | bus.wdata[1:0];
      end else if (w_irq_clr) begin
         irq_mask <= irq_mask & ~bus.wdata[1:0];
      end
   end

   // Oscillator start-up down-counter
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         osc_cnt <= 8'h00;
         osc_stable <= 1'b0;
      end else if (cfg_take && !new_osc_en) begin
         osc_cnt <= 8'h00;
         osc_stable <= 1'b0;
      end else if (osc_start) begin
         osc_cnt <= new_oscnt;
         osc_stable <= 1'b0;
      end else if (cfg_take && new_osc_en && !cur_osc_en) begin
         osc_stable <= 1'b1;
      end else if (osc_tick && osc_cnt != 8'h00) begin
         osc_cnt <= osc_cnt - 8'h01;
         osc_stable <= (osc_cnt == 8'h01);
      end
   end

   // PLL lock down-counter, one step per slow clock period
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pll_cnt <= 8'h00;
         pll_locked <= 1'b0;
      end else if (cfg_take && (!new_osc_en || new_mul == 6'h00)) begin
         pll_cnt <= 8'h00;
         pll_locked <= 1'b0;
      end else if (pll_start) begin
         pll_cnt <= {2'h0, new_pllcnt};
         pll_locked <= 1'b0;
      end else if (cfg_take && new_mul != cur_mul) begin
         pll_locked <= osc_stable;
      end else if (!osc_stable) begin
         pll_locked <= 1'b0;
      end else if (slow_tick && pll_cnt != 8'h00) begin
         pll_cnt <= pll_cnt - 8'h01;
         pll_locked <= (pll_cnt == 8'h01);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pin_state <= PIN_TRIS;
      end else begin
         pin_state <= next_pin_state;
      end
   end

   // Registered views of the clock controls, the status flags and the power-off pin drive
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         osc_enable <= 1'b0;
         osc_bypass <= 1'b0;
         clkout_oe <= 1'b1;
         prescale_sel <= 3'h0;
         pll_multiplier <= 6'h00;
         pll_enable <= 1'b0;
         clock_source_sel <= CSS_SLOW;
         osc_stable_flag <= 1'b0;
         pll_lock_flag <= 1'b0;
         power_off_pin_out <= 1'b0;
         power_off_pin_oe <= 1'b0;
      end else begin
         osc_enable <= cfg[CFG_OSC_EN];
         osc_bypass <= cfg[CFG_BYP];
         clkout_oe <= !cfg[CFG_CKO_DIS];
         prescale_sel <= cfg[CFG_PRESCALE_SEL_LSB +: 3];
         pll_multiplier <= cur_mul;
         pll_enable <= (cur_mul != 6'h00);
         clock_source_sel <= cur_css;
         osc_stable_flag <= osc_stable;
         pll_lock_flag <= pll_locked;
         power_off_pin_out <= (pin_state == PIN_HIGH);
         power_off_pin_oe <= (pin_state == PIN_LOW) || (pin_state == PIN_HIGH);
      end
   end

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (bus.addr)
         OFF_CORE_STATE: rd_mux = {31'h0, core_clk_en};
         OFF_PER_STATE: rd_mux = periph_clk_en;
         OFF_CFG: rd_mux = cfg;
         OFF_PWR_CFG: rd_mux = {24'h0, pwr_cfg};
         OFF_OSC_STATE: rd_mux = {30'h0, pll_locked, osc_stable};
         OFF_IRQ_STATE: rd_mux = {30'h0, irq_mask};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= bus.rd ? rd_mux : 32'h00000000;
      end
   end
endmodule // pcm_regs

// *** tb/pcm_regs_assertions.sv ***
`timescale 1ns/1ps
module pcm_regs_checker
   import pcm_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [pcm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pcm_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [pcm_pkg::DATA_W-1:0] reg_rdata,
   input wire logic core_clk_en,
   input wire logic [pcm_pkg::DATA_W-1:0] periph_clk_en,
   input wire logic osc_enable,
   input wire logic [2:0] prescale_sel,
   input wire logic [1:0] clock_source_sel,
   input wire logic osc_stable_flag,
   input wire logic pll_lock_flag,
   input wire logic power_off_pin_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   wire wr_at_cmd = reg_wr && reg_addr == OFF_PWR_CMD;
   // Gate enables are flops loaded on the strobe edge, so they show one cycle later
   wire wr_core_set = reg_wr && reg_addr == OFF_CORE_SET && reg_wdata[0];
   wire wr_core_clr = reg_wr && reg_addr == OFF_CORE_CLR && reg_wdata[0];
   wire wr_per_set = reg_wr && reg_addr == OFF_PER_SET;
   wire wr_per_clr = reg_wr && reg_addr == OFF_PER_CLR;
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data not zero outside a read answer");
   core_on_a: assert property (wr_core_set |=> core_clk_en)
      else $error("core clock not enabled by set write");
   core_off_a: assert property (wr_core_clr |=> !core_clk_en)
      else $error("core clock not stopped by clear write");
   per_map_a: assert property ((periph_clk_en & ~PER_MASK) == '0)
      else $error("unmapped peripheral enable set");
   per_set_a: assert property (wr_per_set |=>
      (~periph_clk_en & $past(reg_wdata) & PER_MASK) == '0)
      else $error("peripheral set bits not enabled");
   per_clr_a: assert property (wr_per_clr |=> (periph_clk_en & $past(reg_wdata)) == '0)
      else $error("peripheral clear bits still enabled");
   code_valid_a: assert property (clock_source_sel != CSS_RSVD && prescale_sel != PRESCALE_SEL_RSVD)
      else $error("reserved clock code in effect");
   src_safe_a: assert property (clock_source_sel != CSS_SLOW |-> osc_stable_flag)
      else $error("fast source without stable oscillator");
   stable_en_a: assert property (osc_stable_flag |-> osc_enable)
      else $error("stable flag with oscillator off");
   lock_osc_a: assert property (pll_lock_flag |-> osc_stable_flag)
      else $error("lock flag without stable oscillator");
   pin_cause_a: assert property ($changed(power_off_pin_oe) |-> $past(wr_at_cmd, 2))
      else $error("pin drive changed without a command");
   cover property (wr_at_cmd && reg_wdata[1:0] == 2'h3);
   cover property (clock_source_sel == CSS_PLL);
   cover property (pll_lock_flag && osc_stable_flag);
endmodule // pcm_regs_checker

bind pcm_regs pcm_regs_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
   .prescale_sel(prescale_sel), .clock_source_sel(clock_source_sel),
   .osc_stable_flag(osc_stable_flag), .pll_lock_flag(pll_lock_flag),
   .power_off_pin_oe(power_off_pin_oe));

// *** tb/power_clock_manager_regs_tb_top.sv ***
`timescale 1ns/1ps
module power_clock_manager_regs_tb_top;
   import pcm_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, periph_clk_en, d;
   logic core_clk_en, osc_enable, osc_bypass, clkout_oe, pll_enable, osc_stable_flag;
   logic pll_lock_flag, power_off_pin_out, power_off_pin_oe;
   logic [2:0] prescale_sel;
   logic [5:0] pll_multiplier;
   logic [1:0] clock_source_sel;
   int num_errors = 0;
   int total_checks = 0;
   logic [31:0] seed = 32'hA5736E9C;
   logic [31:0] m_per = '0, m_cfg = '0;
   logic m_core = 1'b1, m_stab = 1'b0, m_lock = 1'b0, m_oe = 1'b0, m_out = 1'b0;
   // Bypass is only ever set with the oscillator off
   logic [31:0] cfg_tab [9] = '{32'h1, 32'h70, 32'hC000, 32'h4000, 32'h36,
      32'h4536, 32'h8536, 32'h8036, 32'h536};
   always #2.5 sys_clk = ~sys_clk;
   pcm_regs u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
      .osc_bypass(osc_bypass), .clkout_oe(clkout_oe), .prescale_sel(prescale_sel),
      .pll_multiplier(pll_multiplier), .pll_enable(pll_enable),
      .clock_source_sel(clock_source_sel), .osc_stable_flag(osc_stable_flag),
      .pll_lock_flag(pll_lock_flag), .power_off_pin_out(power_off_pin_out),
      .power_off_pin_oe(power_off_pin_oe));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Mirrors the refusal rules for clock configuration writes
   function automatic bit cfg_ok(input logic [31:0] v);
      if (v[6:4] == PRESCALE_SEL_RSVD || v[15:14] == CSS_RSVD) return 0;
      if (v[15:14] != CSS_SLOW && !(v[1] && m_stab)) return 0;
      if (v[15:14] == CSS_PLL && !(v[13:8] != 0 && v[13:8] == m_cfg[13:8] && m_lock)) return 0;
      if (m_cfg[15:14] == CSS_PLL && v[13:8] == 0) return 0;
      if (m_cfg[15:14] != CSS_SLOW && !v[1]) return 0;
      return 1;
   endfunction
   task automatic cfg_step(input logic [31:0] v);
      if (cfg_ok(v)) begin
         m_lock = m_stab && v[1] && v[13:8] != 0;
         m_stab = v[1];
         m_cfg = v & 32'h3FFFFF77;
      end
      wr(OFF_CFG, v);
      settle(3);
      chk(osc_bypass, m_cfg[0]);
      chk(clkout_oe, !m_cfg[2]);
      chk(prescale_sel, m_cfg[6:4]);
      chk({pll_enable, pll_multiplier}, {m_cfg[13:8] != 0, m_cfg[13:8]});
      chk({osc_enable, clock_source_sel}, {m_cfg[1], m_cfg[15:14]});
      chk({pll_lock_flag, osc_stable_flag}, {m_lock, m_stab});
      rd(OFF_CFG, m_cfg);
      rd(OFF_OSC_STATE, {m_lock, m_stab});
   endtask
   task automatic pw(input logic [31:0] cfg, input logic [31:0] cmd);
      logic [1:0] c;
      wr(OFF_PWR_CFG, cfg);
      wr(OFF_PWR_CMD, cmd);
      c = cmd[1] ? cfg[3:2] : cfg[1:0];
      if (cmd[1:0] != 0 && c != 2'h3) begin
         m_oe = c != PIN_TRIS;
         m_out = c == PIN_HIGH;
      end
      settle(1);
      chk(power_off_pin_oe, m_oe);
      if (m_oe) chk(power_off_pin_out, m_out);
      rd(OFF_PWR_CFG, cfg);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Slow-clock waits of the counter test dominate the run time
   initial begin : watchdog
      #((10 * SLOW_CYC + 10000) * 5);
      num_errors++;
      results();
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(OFF_CORE_STATE, 32'h1);
      rd(OFF_PER_STATE, 32'h0);
      rd(OFF_CFG, 32'h0);
      rd(OFF_PWR_CFG, 32'h1);
      rd(OFF_IRQ_STATE, 32'h0);
      for (int i = 0; i < 17; i++) if ((17'h166BB >> i) & 1) rd(8'(i * 4), 32'h0);
      $display("test reset_reads done");
      for (int i = 0; i < 8; i++) begin
         d = rnd();
         wr(i[0] ? OFF_CORE_CLR : OFF_CORE_SET, d);
         if (d[0]) m_core = !i[0];
         settle(1);
         chk(core_clk_en, m_core);
         rd(OFF_CORE_STATE, m_core);
      end
      for (int i = 0; i < 16; i++) begin
         d = rnd();
         wr(i[0] ? OFF_PER_CLR : OFF_PER_SET, d);
         m_per = i[0] ? m_per & ~d : (m_per | d) & PER_MASK;
         settle(1);
         chk(periph_clk_en, m_per);
         rd(OFF_PER_STATE, m_per);
      end
      $display("test clock_gates done");
      foreach (cfg_tab[i]) cfg_step(cfg_tab[i]);
      for (int p = 0; p < 8; p++) cfg_step(32'h506 | (p << 4));
      cfg_step(32'h0);
      wr(OFF_CFG, 32'h00010002);
      settle(3);
      chk(osc_stable_flag, 32'h0);
      settle(8 * SLOW_CYC);
      chk(osc_stable_flag, 32'h1);
      wr(OFF_CFG, 32'h02000502);
      settle(3);
      chk(pll_lock_flag, 32'h0);
      settle(2 * SLOW_CYC);
      chk(pll_lock_flag, 32'h1);
      rd(OFF_OSC_STATE, 32'h3);
      rd(OFF_CFG, 32'h02000502);
      $display("test clock_config done");
      for (int k = 0; k < 3; k++) pw(k, 1);
      for (int k = 0; k < 3; k++) pw((k << 2) | 1, 2);
      pw(32'h9, 3);
      pw(32'hF, 1);
      pw(32'h1, 0);
      wr(OFF_IRQ_SET, 32'h3);
      rd(OFF_IRQ_STATE, 32'h3);
      wr(OFF_IRQ_CLR, 32'h1);
      rd(OFF_IRQ_STATE, 32'h2);
      $display("test power_pin done");
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(OFF_CORE_STATE, 32'h1);
      rd(OFF_PER_STATE, 32'h0);
      rd(OFF_CFG, 32'h0);
      chk({power_off_pin_oe, clkout_oe, pll_lock_flag, osc_stable_flag}, 32'h4);
      $display("test second_reset done");
      results();
   end
endmodule // power_clock_manager_regs_tb_top
